// [ebct_pkg.sv]
// Shared constants and types for the eight-bit counter/timer
package ebct_pkg;

	// Register offsets, expanded bank
	localparam logic [3:0] ADDR_CTRL0  = 4'h0;
	localparam logic [3:0] ADDR_SHARED = 4'h1;
	localparam logic [3:0] ADDR_T16CTL = 4'h2;
	localparam logic [3:0] ADDR_HOLD_H = 4'h4;
	localparam logic [3:0] ADDR_HOLD_L = 4'h5;
	localparam logic [3:0] ADDR_CAP_P  = 4'h6;
	localparam logic [3:0] ADDR_CAP_N  = 4'h7;
	localparam logic [3:0] ADDR_COUNT  = 4'h8;

	// Eight-bit timer control fields
	localparam int C0_EN      = 7;
	localparam int C0_SINGLE  = 6;
	localparam int C0_TOUT    = 5;
	localparam int C0_DIV_HI  = 4;
	localparam int C0_DIV_LO  = 3;
	localparam int C0_EDGE_IE = 2;
	localparam int C0_TOUT_IE = 1;
	localparam int C0_OUT_EN  = 0;

	// Shared control fields
	localparam int C1_DEMOD    = 6;
	localparam int C1_PP_HI    = 3;
	localparam int C1_PP_LO    = 2;
	localparam int C1_INIT     = 1;
	localparam int C1_POS_FLAG = 1;
	localparam int C1_NEG_FLAG = 0;
	localparam logic [1:0] PP_SELECT = 2'h1;

	// Reset values and count constants
	localparam logic [7:0] CTRL0_RST   = 8'h00;
	localparam logic [7:0] SHARED_RST  = 8'h00;
	localparam logic [7:0] T16CTL_RST  = 8'h00;
	localparam logic [7:0] HOLD_RST    = 8'h00;
	localparam logic [7:0] COUNT_RST   = 8'h00;
	localparam logic [7:0] COUNT_TERM  = 8'h01;
	localparam logic [7:0] COUNT_ZERO  = 8'h00;
	localparam logic [7:0] COUNT_DEMOD = 8'hFF;
	localparam logic [2:0] DIV_RST     = 3'h0;

	typedef enum logic [2:0] {
		EBCT_STOP  = 3'b001,
		EBCT_TX    = 3'b010,
		EBCT_DEMOD = 3'b100
	} ebct_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ebct_regreq_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} ebct_edges_t;

endpackage

// [ebct_edge_sync.sv]
// Two-flop synchroniser and edge detector for the timer input pin
`timescale 1ns/100ps
module ebct_edge_sync
	import ebct_pkg::*;
(
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RESETN,
	// Pin and edges
	input  wire logic        PIN_IN,
	output ebct_edges_t      EDGES
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
		logic fall;
	} ebct_sync_t;

	ebct_sync_t q;
	ebct_sync_t n;

	always_comb begin
		n      = q;
		n.s1   = PIN_IN;
		n.s2   = q.s1;
		n.s3   = q.s2;
		n.rise = q.s2 & ~q.s3;
		n.fall = ~q.s2 & q.s3;
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign EDGES = '{rise: q.rise, fall: q.fall};
endmodule

// [ebct_timer.sv]
// Eight-bit down counter/timer with wave output and edge capture
`timescale 1ns/100ps
module ebct_timer
	import ebct_pkg::*;
(
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RESETN,
	// Register port
	input  ebct_regreq_t     REG_REQ,
	output logic [7:0]       REG_RDATA,
	// Timer pins
	input  wire logic        TIMER_IN,
	output logic             TIMER_WAVE_OUT,
	output logic             TIMER_WAVE_OE,
	// Interrupt request and sixteen-bit timer link
	output logic             TIMER_IRQ,
	output logic             EIGHT_BIT_DONE,
	input  wire logic        SIXTEEN_BIT_DONE,
	output logic [7:0]       SIXTEEN_BIT_CTRL,
	output logic             PING_PONG
);
	typedef struct packed {
		ebct_state_t fsm;
		logic [7:0]  ctrl0;
		logic [7:0]  shared;
		logic [7:0]  t16ctl;
		logic [7:0]  hold_hi;
		logic [7:0]  hold_lo;
		logic [7:0]  pos_cap;
		logic [7:0]  neg_cap;
		logic [7:0]  count;
		logic        wave;
		logic        pos_flag;
		logic        neg_flag;
		logic        first_tc;
		logic [2:0]  div;
		logic [7:0]  rdata;
		logic        irq;
		logic        done;
	} ebct_core_t;

	localparam ebct_core_t CORE_RST = '{
		fsm: EBCT_STOP, ctrl0: CTRL0_RST, shared: SHARED_RST, t16ctl: T16CTL_RST,
		hold_hi: HOLD_RST, hold_lo: HOLD_RST, pos_cap: HOLD_RST, neg_cap: HOLD_RST,
		count: COUNT_RST, wave: 1'b0, pos_flag: 1'b0, neg_flag: 1'b0,
		first_tc: 1'b0, div: DIV_RST, rdata: 8'h00, irq: 1'b0, done: 1'b0};

	ebct_core_t  q;
	ebct_core_t  n;
	ebct_edges_t edges;
	logic        wr0;
	logic        start_req;
	logic        stop_req;
	logic        tick;
	logic        running;
	logic        demod_sel;

	// Divide select: 1, 2, 4 or 8 core clocks per count
	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h0;
		unique case (sel)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			2'h3: m = 3'h7;
		endcase
		return m;
	endfunction

	ebct_edge_sync u_sync (
		.CORE_CLK (CORE_CLK),
		.RESETN   (RESETN),
		.PIN_IN   (TIMER_IN),
		.EDGES    (edges)
	);

	assign wr0       = REG_REQ.wr && (REG_REQ.addr == ADDR_CTRL0);
	assign demod_sel = q.shared[C1_DEMOD];
	assign tick      = (q.div & div_mask(q.ctrl0[C0_DIV_HI:C0_DIV_LO]))
	                   == div_mask(q.ctrl0[C0_DIV_HI:C0_DIV_LO]);
	// Restart also comes from the partner timer in ping-pong
	assign start_req = (q.fsm == EBCT_STOP) && ((wr0 && REG_REQ.wdata[C0_EN])
	                   || (SIXTEEN_BIT_DONE && PING_PONG));
	assign stop_req  = wr0 && !REG_REQ.wdata[C0_EN];
	assign running   = (q.fsm != EBCT_STOP) && !stop_req;

	always_comb begin
		n      = q;
		n.irq  = 1'b0;
		n.done = 1'b0;
		n.div  = q.div + 3'h1;

		// Software writes; clears come first so hardware sets win
		if (REG_REQ.wr) begin
			unique case (REG_REQ.addr)
				ADDR_CTRL0: begin
					n.ctrl0 = REG_REQ.wdata;
					n.ctrl0[C0_TOUT] = q.ctrl0[C0_TOUT] & ~REG_REQ.wdata[C0_TOUT];
				end
				ADDR_SHARED: begin
					n.shared = REG_REQ.wdata;
					if (q.shared[C1_DEMOD]) begin
						n.shared[C1_INIT] = q.shared[C1_INIT];
						n.pos_flag = q.pos_flag & ~REG_REQ.wdata[C1_POS_FLAG];
						n.neg_flag = q.neg_flag & ~REG_REQ.wdata[C1_NEG_FLAG];
					end
				end
				ADDR_T16CTL: n.t16ctl = REG_REQ.wdata;
				// Taken at once, seen by the counter only at reload
				ADDR_HOLD_H: n.hold_hi = REG_REQ.wdata;
				ADDR_HOLD_L: n.hold_lo = REG_REQ.wdata;
				default: ;
			endcase
		end
		if (stop_req) begin
			n.fsm = EBCT_STOP;
		end

		// Counting
		if (running) begin
			unique case (q.fsm)
				EBCT_TX: begin
					if (tick) begin
						// Terminal count is the tick taken at a count of one
						if (q.count == COUNT_TERM) begin
							n.wave = ~q.wave;
							if (q.ctrl0[C0_SINGLE]) begin
								n.count = COUNT_ZERO;
								n.fsm = EBCT_STOP;
								n.ctrl0[C0_EN] = 1'b0;
								n.ctrl0[C0_TOUT] = 1'b1;
								n.irq = q.ctrl0[C0_TOUT_IE];
								n.done = 1'b1;
							end else begin
								n.count = q.wave ? q.hold_lo : q.hold_hi;
								n.first_tc = 1'b0;
								if (!q.first_tc) begin
									n.ctrl0[C0_TOUT] = 1'b1;
									n.irq = q.ctrl0[C0_TOUT_IE];
								end
							end
						end else begin
							n.count = q.count - 8'h01;
						end
					end
				end
				EBCT_DEMOD: begin
					if (edges.rise) begin
						n.pos_cap = q.count;
						n.pos_flag = 1'b1;
						n.count = COUNT_DEMOD;
						n.irq = q.ctrl0[C0_EDGE_IE];
					end else if (edges.fall) begin
						n.neg_cap = q.count;
						n.neg_flag = 1'b1;
						n.count = COUNT_DEMOD;
						n.irq = q.ctrl0[C0_EDGE_IE];
					end else if (tick) begin
						if (q.count == COUNT_TERM) begin
							n.ctrl0[C0_TOUT] = 1'b1;
							n.irq = q.ctrl0[C0_TOUT_IE];
						end
						n.count = q.count - 8'h01;
					end
				end
				default: n.fsm = EBCT_STOP;
			endcase
		end

		// Any start reloads from the holding registers
		if (start_req) begin
			n.fsm = demod_sel ? EBCT_DEMOD : EBCT_TX;
			n.ctrl0[C0_EN] = 1'b1;
			n.wave = q.shared[C1_INIT];
			n.count = q.shared[C1_INIT] ? q.hold_hi : q.hold_lo;
			n.first_tc = 1'b1;
			n.div = DIV_RST;
		end

		// Registered read data
		if (REG_REQ.rd) begin
			unique case (REG_REQ.addr)
				ADDR_CTRL0:  n.rdata = q.ctrl0;
				ADDR_SHARED: n.rdata = q.shared[C1_DEMOD]
				                       ? {q.shared[7:2], q.pos_flag, q.neg_flag} : q.shared;
				ADDR_T16CTL: n.rdata = q.t16ctl;
				ADDR_HOLD_H: n.rdata = q.hold_hi;
				ADDR_HOLD_L: n.rdata = q.hold_lo;
				ADDR_CAP_P:  n.rdata = q.pos_cap;
				ADDR_CAP_N:  n.rdata = q.neg_cap;
				ADDR_COUNT:  n.rdata = q.count;
				default:     n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			q <= CORE_RST;
		end else begin
			q <= n;
		end
	end

	assign REG_RDATA        = q.rdata;
	assign TIMER_WAVE_OUT   = q.wave;
	assign TIMER_WAVE_OE    = q.ctrl0[C0_OUT_EN];
	assign TIMER_IRQ        = q.irq;
	assign EIGHT_BIT_DONE   = q.done;
	assign SIXTEEN_BIT_CTRL = q.t16ctl;
	assign PING_PONG        = q.shared[C1_PP_HI:C1_PP_LO] == PP_SELECT;

	// Checks
	logic tx_term;
	logic dm_run;
	assign tx_term = running && !start_req && (q.fsm == EBCT_TX) && tick
	                 && (q.count == COUNT_TERM);
	assign dm_run  = running && !start_req && (q.fsm == EBCT_DEMOD);

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	a_start_level: assert property (start_req |=> TIMER_WAVE_OUT == $past(q.shared[C1_INIT]))
		else $error("start level wrong");
	a_start_load: assert property (start_req |=> q.count ==
		($past(q.shared[C1_INIT]) ? $past(q.hold_hi) : $past(q.hold_lo)))
		else $error("start load wrong");
	a_single_stop: assert property (tx_term && q.ctrl0[C0_SINGLE] && !REG_REQ.wr
		|=> q.fsm == EBCT_STOP && q.ctrl0[C0_TOUT] && EIGHT_BIT_DONE
		&& TIMER_WAVE_OUT != $past(TIMER_WAVE_OUT))
		else $error("single pass end wrong");
	a_mod_quiet: assert property (tx_term && !q.ctrl0[C0_SINGLE] && q.first_tc
		|=> !TIMER_IRQ && TIMER_WAVE_OUT != $past(TIMER_WAVE_OUT))
		else $error("first modulo count interrupted");
	a_mod_reload: assert property (tx_term && !q.ctrl0[C0_SINGLE]
		|=> q.count == (TIMER_WAVE_OUT ? $past(q.hold_hi) : $past(q.hold_lo)))
		else $error("modulo reload wrong");
	a_zero_wrap: assert property (running && !start_req && q.fsm == EBCT_TX && tick
		&& q.count == COUNT_ZERO |=> q.count == 8'hFF)
		else $error("zero did not wrap");
	a_pos_capture: assert property (dm_run && edges.rise |=> q.pos_cap == $past(q.count)
		&& q.count == COUNT_DEMOD && q.pos_flag)
		else $error("positive capture wrong");
	a_edge_irq: assert property (dm_run && (edges.rise || edges.fall)
		|=> TIMER_IRQ == $past(q.ctrl0[C0_EDGE_IE]))
		else $error("edge interrupt wrong");
	a_demod_tout: assert property (dm_run && !edges.rise && !edges.fall && tick
		&& q.count == COUNT_TERM |=> q.ctrl0[C0_TOUT] && q.fsm == EBCT_DEMOD
		&& q.count == COUNT_ZERO && TIMER_IRQ == $past(q.ctrl0[C0_TOUT_IE]))
		else $error("demod timeout wrong");
	a_demod_wrap: assert property (dm_run && !edges.rise && !edges.fall && tick
		&& q.count == COUNT_ZERO |=> q.count == COUNT_DEMOD)
		else $error("demod did not continue from FF");
	a_neg_capture: assert property (dm_run && edges.fall && !edges.rise
		|=> q.neg_cap == $past(q.count) && q.count == COUNT_DEMOD && q.neg_flag)
		else $error("negative capture wrong");

	// Counting, halting and interrupts
	a_single_irq: assert property (tx_term && q.ctrl0[C0_SINGLE]
		|=> TIMER_IRQ == $past(q.ctrl0[C0_TOUT_IE]))
		else $error("single pass interrupt wrong");
	a_mod_later: assert property (tx_term && !q.ctrl0[C0_SINGLE] && !q.first_tc
		|=> q.ctrl0[C0_TOUT] && TIMER_IRQ == $past(q.ctrl0[C0_TOUT_IE]))
		else $error("modulo timeout wrong");
	a_count_step: assert property (running && !start_req && q.fsm == EBCT_TX && tick
		&& q.count != COUNT_TERM |=> q.count == $past(q.count) - 8'h01)
		else $error("count step wrong");
	a_count_hold: assert property (running && !start_req && q.fsm != EBCT_STOP && !tick
		&& !edges.rise && !edges.fall |=> q.count == $past(q.count))
		else $error("count moved without tick");
	a_stop_halts: assert property (stop_req && !start_req
		|=> q.fsm == EBCT_STOP && !q.ctrl0[C0_EN])
		else $error("stop did not halt");
	a_tout_sticky: assert property (q.ctrl0[C0_TOUT] && !(wr0 && REG_REQ.wdata[C0_TOUT])
		|=> q.ctrl0[C0_TOUT])
		else $error("timeout flag lost");

	c_single_end: cover property (tx_term && q.ctrl0[C0_SINGLE]);
	c_mod_second: cover property (tx_term && !q.ctrl0[C0_SINGLE] && !q.first_tc);
	c_neg_capture: cover property (dm_run && edges.fall);
	c_ping_pong: cover property (start_req && SIXTEEN_BIT_DONE);
	c_divided: cover property (tx_term && q.ctrl0[C0_DIV_HI:C0_DIV_LO] == 2'h3);
endmodule

// [tb_top.sv]
// Self-checking testbench for the eight-bit counter/timer
`timescale 1ns/100ps
module tb_top;
	import ebct_pkg::*;

	logic         core_clk = 1'b0;
	logic         resetn   = 1'b0;
	ebct_regreq_t reg_req  = '0;
	logic [7:0]   reg_rdata;
	logic         timer_in = 1'b0;
	logic         wave;
	logic         wave_oe;
	logic         irq;
	logic         done8;
	logic         done16   = 1'b0;
	logic [7:0]   t16_ctrl;
	logic         ping_pong;
	int           mismatches = 0;
	int           n_checks   = 0;
	logic [7:0]   rv;

	always #25 core_clk = ~core_clk;

	ebct_timer ebct_timer_i (
		.CORE_CLK(core_clk), .RESETN(resetn), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
		.TIMER_IN(timer_in), .TIMER_WAVE_OUT(wave), .TIMER_WAVE_OE(wave_oe), .TIMER_IRQ(irq),
		.EIGHT_BIT_DONE(done8), .SIXTEEN_BIT_DONE(done16), .SIXTEEN_BIT_CTRL(t16_ctrl),
		.PING_PONG(ping_pong)
	);

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp8(logic [7:0] got, logic [7:0] exp, string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Request held one edge, then a quiet cycle
	task automatic wr(logic [3:0] a, logic [7:0] d);
		reg_req = ebct_regreq_t'{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		#1 reg_req = '0;
		@(posedge core_clk);
		#1;
	endtask

	task automatic rd(logic [3:0] a);
		reg_req = ebct_regreq_t'{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		#1 reg_req = '0;
		rv = reg_rdata;
		@(posedge core_clk);
		#1;
	endtask

	// Bounded wait for irq (0) or done (1) pulse
	task automatic wait_for(input int which, output int k);
		for (k = 1; k <= 400; k++) begin
			@(posedge core_clk);
			#1;
			if ((which == 0 && irq === 1'b1) || (which == 1 && done8 === 1'b1)) return;
		end
		mismatches++;
		$display("CHECK FAILED at %0t: wait timed out", $time);
		tally_and_finish();
	endtask

	task automatic t_single();
		int k1;
		int k0;
		wr(ADDR_HOLD_H, 8'h03);
		wr(ADDR_HOLD_L, 8'h09);
		wr(ADDR_SHARED, 8'h02);
		wr(ADDR_CTRL0, 8'hC3);
		cmp8({7'h0, wave}, 8'h01, "initial level");
		cmp8({7'h0, wave_oe}, 8'h01, "output enable");
		wait_for(1, k1);
		cmp8({7'h0, irq}, 8'h01, "irq at end");
		cmp8({7'h0, wave}, 8'h00, "toggle at end");
		rd(ADDR_CTRL0);
		cmp8(rv & 8'hA0, 8'h20, "flag set, halted");
		rd(ADDR_COUNT);
		cmp8(rv, 8'h00, "halted at zero");
		wr(ADDR_SHARED, 8'h00);
		wr(ADDR_CTRL0, 8'hC0);
		wait_for(1, k0);
		cmp8({7'h0, irq}, 8'h00, "irq masked");
		cmp8({7'h0, wave}, 8'h01, "toggle from low");
		cmp8(8'(k0 - k1), 8'h06, "low holding used");
		$display("test single-pass done");
	endtask

	task automatic t_modulo();
		int t[4];
		int n;
		int nirq;
		logic w;
		n = 0;
		nirq = 0;
		wr(ADDR_HOLD_H, 8'h02);
		wr(ADDR_HOLD_L, 8'h04);
		wr(ADDR_CTRL0, 8'h83);
		w = wave;
		for (int i = 0; i < 60 && n < 4; i++) begin
			@(posedge core_clk);
			#1;
			// Rewrite high holding just after the first toggle
			reg_req = (wave !== w && n == 0) ?
				ebct_regreq_t'{1'b1, 1'b0, ADDR_HOLD_H, 8'h03} : ebct_regreq_t'('0);
			if (irq === 1'b1) nirq++;
			if (wave !== w) begin
				cmp8({7'h0, irq}, (n == 0) ? 8'h00 : 8'h01, "irq on toggle");
				t[n] = i;
				n++;
				w = wave;
			end
		end
		reg_req = '0;
		cmp8(8'(n), 8'h04, "toggle count");
		cmp8(8'(t[1] - t[0]), 8'h02, "high period");
		cmp8(8'(t[2] - t[1]), 8'h04, "low period");
		cmp8(8'(t[3] - t[2]), 8'h03, "new high value");
		cmp8(8'(nirq), 8'h03, "irq count");
		wr(ADDR_CTRL0, 8'h00);
		rd(ADDR_CTRL0);
		cmp8(rv & 8'h20, 8'h20, "flag sticky");
		wr(ADDR_CTRL0, 8'h20);
		rd(ADDR_CTRL0);
		cmp8(rv & 8'h20, 8'h00, "flag cleared");
		$display("test modulo done");
	endtask

	task automatic t_wrap();
		logic [7:0] prev;
		bit hit;
		int k;
		prev = 8'h00;
		hit = 1'b0;
		wr(ADDR_HOLD_L, 8'h00);
		wr(ADDR_CTRL0, 8'hC0);
		reg_req = ebct_regreq_t'{1'b0, 1'b1, ADDR_COUNT, 8'h00};
		repeat (6) begin
			@(posedge core_clk);
			#1;
			if (prev === 8'hFF && reg_rdata === 8'hFE) hit = 1'b1;
			prev = reg_rdata;
		end
		reg_req = '0;
		cmp8({7'h0, hit}, 8'h01, "wrap through FF");
		wr(ADDR_CTRL0, 8'h40);
		wr(ADDR_T16CTL, 8'h40);
		wr(ADDR_SHARED, 8'h04);
		cmp8(t16_ctrl, 8'h40, "partner control");
		cmp8({7'h0, ping_pong}, 8'h01, "ping-pong");
		done16 = 1'b1;
		@(posedge core_clk);
		#1 done16 = 1'b0;
		rd(ADDR_CTRL0);
		cmp8(rv & 8'h80, 8'h80, "partner start");
		wr(ADDR_CTRL0, 8'h00);
		// Divide by eight: five ticks of eight clocks each
		wr(ADDR_HOLD_L, 8'h05);
		wr(ADDR_CTRL0, 8'hD8);
		wait_for(1, k);
		cmp8(8'(k), 8'h27, "divide by eight");
		$display("test wrap and ping-pong done");
	endtask

	task automatic t_demod();
		int k;
		wr(ADDR_SHARED, 8'h40);
		wr(ADDR_HOLD_L, 8'h80);
		wr(ADDR_CTRL0, 8'h86);
		timer_in = 1'b1;
		wait_for(0, k);
		// Falling edge 20 cycles after rise, rise 30 after that
		for (int e = 0; e < 2; e++) begin
			repeat (20 + 10 * e - k) begin
				@(posedge core_clk);
				#1;
			end
			timer_in = ~timer_in;
			wait_for(0, k);
		end
		rd(ADDR_CAP_N);
		cmp8(rv, 8'hEC, "negative capture");
		rd(ADDR_CAP_P);
		cmp8(rv, 8'hE2, "positive capture");
		rd(ADDR_SHARED);
		cmp8(rv, 8'h43, "edge flags");
		wr(ADDR_SHARED, 8'h43);
		rd(ADDR_SHARED);
		cmp8(rv, 8'h40, "edge flags cleared");
		wait_for(0, k);
		rd(ADDR_CTRL0);
		cmp8(rv & 8'hA0, 8'hA0, "timeout, running");
		rd(ADDR_COUNT);
		cmp8({7'h0, rv > 8'hF0}, 8'h01, "from FF");
		wr(ADDR_CTRL0, 8'h00);
		$display("test demodulation done");
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		#1 resetn = 1'b1;
		t_single();
		t_modulo();
		t_wrap();
		t_demod();
		tally_and_finish();
	end
endmodule
